// ==== rwc_defs.svh ====
// Offsets, field positions, reset values and timing counts
`ifndef RWC_DEFS_SVH
`define RWC_DEFS_SVH

`define RWC_OFF_CONFIG      8'h00
`define RWC_OFF_OPTION      8'h04
`define RWC_OFF_STATUS      8'h08
`define RWC_OFF_CONTROL     8'h0C
`define RWC_CFG_RSTPIN_BIT  4
`define RWC_CFG_WDOG_BIT    2
`define RWC_CFG_RESET       12'h014
`define RWC_OPT_RESET       8'hFF
`define RWC_OPT_ASSIGN_BIT  3
`define RWC_ST_CWAKE_BIT    7
`define RWC_ST_PWAKE_BIT    6
`define RWC_ST_TO_BIT       4
`define RWC_ST_PD_BIT       3
`define RWC_ST_SLEEP_BIT    0
`define RWC_CTL_WATCHDOG_CLEAR_OP_BIT  0
`define RWC_CTL_SLEEP_BIT   1
`define RWC_CLK_MHZ         200
`define RWC_DRT_POR_MS      18
`define RWC_DRT_SUB_US      10
`define RWC_WDT_MS          18
`define RWC_WDT_OSC_DIV     20
`define RWC_DRT_POR_CYC     (`RWC_DRT_POR_MS * 1000 * `RWC_CLK_MHZ)
`define RWC_DRT_SUB_CYC     (`RWC_DRT_SUB_US * `RWC_CLK_MHZ)
`define RWC_WDT_TICKS       \
  ((`RWC_WDT_MS * 1000 * `RWC_CLK_MHZ) / `RWC_WDT_OSC_DIV)

`endif

// ==== rwc_pkg.sv ====
// Types for the reset and watchdog block
package rwc_pkg;

  typedef enum logic [1:0] {
    RWC_POR  = 2'b00,
    RWC_HOLD = 2'b01,
    RWC_RUN  = 2'b11
  } rwc_state_e;

  typedef struct packed {
    logic cwake;
    logic pwake;
    logic to_n;
    logic pd_n;
  } rwc_flags_s;

  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } rwc_axi_addr_s;

endpackage

// ==== rwc_reset_watchdog.sv ====
// Reset sequencer, device reset timer and watchdog with AXI4-Lite regs
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rwc_defs.svh"

module rwc_reset_watchdog #(
  parameter int DRT_POR_CYC = `RWC_DRT_POR_CYC,
  parameter int DRT_SUB_CYC = `RWC_DRT_SUB_CYC,
  parameter int WDT_TICKS   = `RWC_WDT_TICKS,
  parameter int WDT_DIV     = `RWC_WDT_OSC_DIV
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_shared_input_pin,
  input  wire logic        i_pin_change,
  input  wire logic        i_comparator_change,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             o_core_reset,
  output logic             o_main_osc_en,
  output logic             o_gpio_in,
  output rwc_pkg::rwc_flags_s o_flags
);
  import rwc_pkg::*;

  rwc_state_e  state_ff;
  logic [11:0] cfg_ff;
  logic [7:0]  option_ff;
  rwc_flags_s  flags_ff;
  logic        sleep_ff;
  logic        por_ff;
  logic [31:0] drt_cnt_ff;
  logic [31:0] drt_lim_ff;
  logic [7:0]  wosc_cnt_ff;
  logic        wtick;
  logic [6:0]  pre_cnt_ff;
  logic [31:0] wdt_cnt_ff;
  logic        pin_low_prev_ff;
  logic        aw_ff;
  logic        w_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic        bad_w_ff;
  logic [7:0]  waddr;
  logic        do_write;
  logic        clr_op;
  logic        sleep_op;
  logic        rst_en;
  logic        wdt_en;
  logic        ext_low;
  logic        wdt_to;
  logic        wake_pin;
  logic        wake_cmp;
  logic        ext_fall;
  logic        restart;
  logic        pre_tick;
  logic [7:0]  pre_mask;
  logic [3:0]  wstrb_ff;
  logic        cfg_wr;
  logic        opt_wr;
  logic        ctl_wr;

  // Reset pin select
  // pin select
  assign rst_en  = cfg_ff[`RWC_CFG_RSTPIN_BIT];
  assign ext_low = rst_en & ~i_shared_input_pin;
  // With the pin disabled as reset it never restarts the device
  assign o_gpio_in = rst_en ? 1'b1 : i_shared_input_pin;
  assign wdt_en  = cfg_ff[`RWC_CFG_WDOG_BIT];

  // Register map, one word each, low byte significant:
  //   0x00 configuration, writable only while the core is held
  //        bit 4 pin reset enable, bit 2 watchdog enable
  //   0x04 option, write-only, back to all ones on any device reset
  //        bit 3 assigns the prescaler, bits 2:0 pick the ratio
  //   0x08 status, read-only: bit 7 comparator wake, bit 6 pin wake,
  //        bit 4 timeout_flag_n, bit 3 powerdown_flag_n, bit 0 asleep
  //   0x0C control, write-only: bit 0 clears watchdog, bit 1 sleeps
  // Unmapped offsets answer with a slave error on either channel.

  // AXI write path
  // Response waits for both halves; a second write is refused meanwhile
  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
  assign do_write = aw_ff & w_ff & ~s_axi_bvalid;
  assign waddr    = awaddr_ff[7:0];
  // All writable bits sit in byte lane 0
  assign cfg_wr   = do_write & (waddr == `RWC_OFF_CONFIG) &
                    wstrb_ff[0] & o_core_reset;
  assign opt_wr   = do_write & (waddr == `RWC_OFF_OPTION) &
                    wstrb_ff[0];
  assign ctl_wr   = do_write & (waddr == `RWC_OFF_CONTROL) &
                    wstrb_ff[0] & ~o_core_reset;
  assign clr_op   = ctl_wr & wdata_ff[`RWC_CTL_WATCHDOG_CLEAR_OP_BIT];
  assign sleep_op = ctl_wr & wdata_ff[`RWC_CTL_SLEEP_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
    end else if (do_write) begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_axi_bvalid <= 1'b0;
      bad_w_ff     <= 1'b0;
    end else if (do_write) begin
      // Error response for offsets outside the map and for the read-only status word
      s_axi_bvalid <= 1'b1;
      bad_w_ff     <= (waddr != `RWC_OFF_CONFIG) &&
                      (waddr != `RWC_OFF_OPTION) &&
                      (waddr != `RWC_OFF_CONTROL);
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = bad_w_ff ? 2'b10 : 2'b00;

  // Configuration word, writable only while the core is in reset
  // config layout
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_ff <= `RWC_CFG_RESET;
    end else if (cfg_wr) begin
      // Bits outside the two enable positions always read as zero
      cfg_ff <= wdata_ff[11:0] & `RWC_CFG_RESET;
    end
  end

  // Option register, reset to all ones by any device reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || restart) begin
      option_ff <= `RWC_OPT_RESET;
    end else if (opt_wr) begin
      option_ff <= wdata_ff[7:0];
    end
  end

  // AXI read path
  // Data latched with the address, so it stands until taken
  // Option and control are write-only and read back as zero
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case (s_axi_araddr[7:0])
        `RWC_OFF_CONFIG: s_axi_rdata <= {20'h0, cfg_ff};
        `RWC_OFF_STATUS: s_axi_rdata <= {24'h0, flags_ff.cwake,
                           flags_ff.pwake, 1'b0, flags_ff.to_n,
                           flags_ff.pd_n, 2'b00, sleep_ff};
        `RWC_OFF_OPTION, `RWC_OFF_CONTROL: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Watchdog oscillator stand-in: free-running enable, never gated by sleep
  // own tick
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || wtick) begin
      wosc_cnt_ff <= 8'h00;
    end else begin
      wosc_cnt_ff <= wosc_cnt_ff + 8'h01;
    end
  end
  assign wtick = (wosc_cnt_ff == 8'(WDT_DIV - 1));

  // Prescaler ratio 2^ps when assigned, else 1:1
  // Ones below the selected bit mark the last count of a period
  // ratio select
  assign pre_mask = option_ff[`RWC_OPT_ASSIGN_BIT] ?
                    ((8'h01 << option_ff[2:0]) - 8'h01) : 8'h00;
  assign pre_tick = wtick & ((pre_cnt_ff & pre_mask[6:0]) == pre_mask[6:0]);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || clr_op || sleep_op || restart || !wdt_en) begin
      pre_cnt_ff <= 7'h00;
    end else if (wtick) begin
      pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
  end

  // Counter and prescaler held clear while the enable is off
  // timeout count
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || clr_op || sleep_op || restart || !wdt_en) begin
      wdt_cnt_ff <= 32'h0;
    end else if (pre_tick) begin
      wdt_cnt_ff <= wdt_cnt_ff + 32'h1;
    end
  end
  assign wdt_to = wdt_en && pre_tick && (wdt_cnt_ff == 32'(WDT_TICKS - 1));

  // Pin change takes priority over a comparator change in one cycle
  // Pin restart fires on the falling edge; the hold follows the level
  assign wake_pin = sleep_ff & i_pin_change;
  assign wake_cmp = sleep_ff & i_comparator_change & ~i_pin_change;
  assign ext_fall = ext_low & ~pin_low_prev_ff;
  assign restart  = ext_fall | wdt_to | wake_pin | wake_cmp;

  always_ff @(posedge i_clk) begin
    // Starts as if low, so a pin held low at power-up is no restart
    if (!i_rst_n) begin
      pin_low_prev_ff <= 1'b1;
    end else begin
      pin_low_prev_ff <= ext_low;
    end
  end

  // Reset latch and device reset timer
  // power-up latch
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff   <= RWC_POR;
      drt_cnt_ff <= 32'h0;
      drt_lim_ff <= 32'(DRT_POR_CYC);
      por_ff     <= 1'b1;
    end else if (restart) begin
      // A restart inside the power-up hold keeps the long period
      state_ff   <= RWC_HOLD;
      drt_cnt_ff <= 32'h0;
      drt_lim_ff <= por_ff ? 32'(DRT_POR_CYC) : 32'(DRT_SUB_CYC);
    end else begin
      unique case (state_ff)
        RWC_POR: begin
          state_ff <= RWC_HOLD;
        end
        RWC_HOLD: begin
          // Any low on the pin, while it is enabled as reset, starts the count over
          if (ext_low) begin
            drt_cnt_ff <= 32'h0;
          end else if (drt_cnt_ff == drt_lim_ff - 32'h1) begin
            state_ff <= RWC_RUN;
            por_ff   <= 1'b0;
          end else begin
            drt_cnt_ff <= drt_cnt_ff + 32'h1;
          end
        end
        RWC_RUN: begin
          state_ff <= RWC_RUN;
        end
        default: state_ff <= RWC_POR;
      endcase
    end
  end
  // Decoded from the state register alone, so it has no glitch
  assign o_core_reset = (state_ff != RWC_RUN);

  // Sleep state and main oscillator gate
  // sleep entry
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || restart) begin
      sleep_ff <= 1'b0;
    end else if (sleep_op) begin
      sleep_ff <= 1'b1;
    end
  end
  // Only a restart or i_rst_n leaves sleep and restarts the main clock
  assign o_main_osc_en = ~sleep_ff;

  // Reset-cause flags
  // Timeout outranks a wake in the same cycle
  // A pin fall while awake only clears the wake flags
  // hold
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_ff <= '{cwake: 1'b0, pwake: 1'b0, to_n: 1'b1, pd_n: 1'b1};
    end else if (wdt_to) begin
      flags_ff.cwake <= 1'b0;
      flags_ff.pwake <= 1'b0;
      flags_ff.to_n  <= 1'b0;
      if (sleep_ff) begin
        flags_ff.pd_n <= 1'b0;
      end
    end else if (wake_pin || wake_cmp) begin
      flags_ff <= '{cwake: wake_cmp, pwake: wake_pin, to_n: 1'b1,
                    pd_n: 1'b0};
    end else if (ext_fall) begin
      flags_ff.cwake <= 1'b0;
      flags_ff.pwake <= 1'b0;
      if (sleep_ff) begin
        flags_ff.to_n <= 1'b1;
        flags_ff.pd_n <= 1'b0;
      end
    end else if (sleep_op) begin
      flags_ff.to_n <= 1'b1;
      flags_ff.pd_n <= 1'b0;
    end
  end
  assign o_flags = flags_ff;

endmodule

// ==== rwc_reset_watchdog_assertions.sv ====
// Concurrent checks on the reset and watchdog block ports
`timescale 1ns/1ps
module rwc_reset_watchdog_assertions (
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_shared_input_pin,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               o_core_reset,
  input wire logic               o_main_osc_en,
  input wire logic               o_gpio_in,
  input wire rwc_pkg::rwc_flags_s o_flags
);
  import rwc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_boot;
    $rose(i_rst_n);
  endsequence
  a_boot_hold: assert property (s_boot |-> o_core_reset [*8])
    else $error("core reset not held after power-up");
  a_por_flags: assert property (s_boot |-> o_flags == 4'h3)
    else $error("power-up flags wrong");
  a_gpio_idle: assert property (!o_gpio_in |-> !i_shared_input_pin)
    else $error("gpio input low while pin high");
  a_sleep_flags: assert property ($fell(o_main_osc_en) |->
    o_flags.to_n && !o_flags.pd_n)
    else $error("sleep entry flags wrong");
  a_flags_hold: assert property ($changed(o_flags) |->
    o_core_reset || !o_main_osc_en || !$past(o_main_osc_en))
    else $error("flags changed without reset");
  a_drt_pin: assert property ($fell(o_core_reset) |->
    $past(i_shared_input_pin, 2) || !o_gpio_in)
    else $error("reset released while pin low");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule

// ==== rwc_pin_model.sv ====
// Shared reset pin with pull-up, pulled low on request
`timescale 1ns/1ps
module rwc_pin_model (
  input  wire logic i_press,
  output logic      o_pin
);
  // Released pin rests at the pull-up level
  assign o_pin = i_press ? 1'h0 : 1'h1;
endmodule

// ==== tb.sv ====
// Self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
module tb;
  import rwc_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, press = 0;
  logic        i_pin_change = 0, i_comparator_change = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, i_shared_input_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic        o_core_reset, o_main_osc_en, o_gpio_in;
  rwc_flags_s  o_flags;
  logic [3:0]  exp_f [4] = '{4'h6, 4'hA, 4'h2, 4'h0};
  int          miscompares = 0, checked = 0, n;
  always #2.5 i_clk = ~i_clk;
  rwc_pin_model u_pin (.i_press(press), .o_pin(i_shared_input_pin));
  rwc_reset_watchdog #(.DRT_POR_CYC(50), .DRT_SUB_CYC(10),
    .WDT_TICKS(20), .WDT_DIV(2)) u_dut (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic ta = 0, tw = 0;
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge i_clk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      @(posedge i_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!(ta && tw));
    do @(negedge i_clk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    @(posedge i_clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge i_clk); while (s_axi_arready !== 1'h1);
    @(posedge i_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge i_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge i_clk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (o_core_reset !== v && n < 6000) begin
      @(negedge i_clk);
      n++;
    end
    chk(n < 6000, 1);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(negedge i_clk);
    chk(o_flags, 4'h3);
    wt(1'h0);
    chk(n >= 48 && n <= 56, 1);
    rd(32'h08);
    chk(d, 32'h18);
    rd(32'h00);
    chk(d, 32'h14);
    rd(32'h04);
    chk(d, 32'h00);
    rd(32'h10);
    chk(r, 2'h2);
    wr(32'h00, 32'h00);
    chk(r, 2'h0);
    wr(32'h10, 32'h00);
    chk(r, 2'h2);
    rd(32'h00);
    chk(d, 32'h14);
    @(posedge i_clk);
    press <= 1'h1;
    repeat (3) @(posedge i_clk);
    chk(o_core_reset, 1);
    press <= 1'h0;
    wt(1'h0);
    chk(n >= 9 && n <= 15, 1);
    chk(o_flags, 4'h3);
    wr(32'h04, 32'h00);
    wt(1'h1);
    chk(n >= 30 && n <= 48, 1);
    chk(o_flags, 4'h1);
    wt(1'h0);
    wr(32'h04, 32'h00);
    repeat (6) begin
      repeat (20) @(posedge i_clk);
      wr(32'h0C, 32'h01);
    end
    chk(o_core_reset, 0);
    for (int k = 0; k < 4; k++) begin
      wr(32'h04, 32'h00);
      wr(32'h0C, 32'h02);
      @(negedge i_clk);
      chk({o_main_osc_en, o_flags.to_n, o_flags.pd_n}, 3'h2);
      @(posedge i_clk);
      i_pin_change <= k == 0;
      i_comparator_change <= k == 1;
      press <= k == 2;
      wt(1'h1);
      chk(o_flags, exp_f[k]);
      if (k == 3) chk(n >= 34 && n <= 48, 1);
      @(posedge i_clk);
      {i_pin_change, i_comparator_change, press} <= 3'h0;
      wt(1'h0);
      chk(o_main_osc_en, 1);
    end
    @(posedge i_clk);
    press <= 1'h1;
    wt(1'h1);
    wr(32'h00, 32'h00);
    press <= 1'h0;
    wt(1'h0);
    rd(32'h00);
    chk(d, 32'h00);
    wr(32'h04, 32'h00);
    press <= 1'h1;
    repeat (100) @(posedge i_clk);
    chk({o_core_reset, o_gpio_in}, 2'h0);
    stop_test();
  end
endmodule
bind rwc_reset_watchdog rwc_reset_watchdog_assertions u_chk (.*);
